// File: rtl/fcs_regs.svh
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
// How it works
// - Host writes a cycle with chip select low, gate high, strobe falling.
// - Cycles may also be written with strobe low and chip select pulsed.
// - Byte program is three unlock cycles then address and data.
// - Chip erase uses six cycles ending with 10H to 555H.
// - Sector erase uses five cycles then 30H at the sector address.
// - Extra sector cycles must start within 100 us of the previous one.
`define FCS_UNLOCK_ADDR1  11'h555
`define FCS_UNLOCK_ADDR2  11'h2aa
`define FCS_UNLOCK_DATA1  8'haa
`define FCS_UNLOCK_DATA2  8'h55
`define FCS_CMD_RESET     8'hf0
`define FCS_CMD_AUTOSEL   8'h90
`define FCS_CMD_PROGRAM   8'ha0
`define FCS_CMD_ERASE     8'h80
`define FCS_CMD_CHIP      8'h10
`define FCS_CMD_SECTOR    8'h30
`define FCS_CMD_SUSPEND   8'hb0
`define FCS_CMD_RESUME    8'h30
`define FCS_POLL_BIT      7
`define FCS_TIMEOUT_BIT   5
`define FCS_ADDR_W        20
`define FCS_SECTOR_LSB    13
`define FCS_SETUP_NS      50
`define FCS_PULSE_NS      75
`define FCS_RECOVER_NS    50
`define FCS_GAP_US        100
`define FCS_CLK_NS        25
`endif

// File: rtl/fcs_pkg.sv
package fcs_pkg;
	typedef enum logic [3:0] {
		FCS_OP_RESET     = 4'h0,
		FCS_OP_RESET3    = 4'h1,
		FCS_OP_AUTOSEL   = 4'h2,
		FCS_OP_PROGRAM   = 4'h3,
		FCS_OP_CHIP      = 4'h4,
		FCS_OP_SECTOR    = 4'h5,
		FCS_OP_ADD_SEC   = 4'h6,
		FCS_OP_SUSPEND   = 4'h7,
		FCS_OP_RESUME    = 4'h8,
		FCS_OP_READ      = 4'h9
	} fcs_op_e;
	// One host request
	typedef struct packed {
		fcs_op_e     op;
		logic [19:0] addr;
		logic [7:0]  data;
	} fcs_req_s;
	// Flash pin drive
	typedef struct packed {
		logic        chip_sel_n;
		logic        out_gate_n;
		logic        wr_strobe_n;
		logic [19:0] addr;
	} fcs_pins_s;
	// One bus cycle for the pin engine
	typedef struct packed {
		logic        is_read;
		logic [19:0] addr;
		logic [7:0]  data;
	} fcs_cyc_s;
endpackage : fcs_pkg

// File: rtl/fcs_bus_cycle.sv
`timescale 1ns/1ps
`include "fcs_regs.svh"
// Drives one write or read cycle on the flash pins
module fcs_bus_cycle (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              cyc_valid,
	output logic                   cyc_ready,
	input  wire fcs_pkg::fcs_cyc_s cyc,
	output fcs_pkg::fcs_pins_s     pins,
	output logic [7:0]             byte_lines_out,
	output logic                   byte_lines_oe,
	input  wire logic [7:0]        byte_lines_in,
	output logic                   done,
	output logic [7:0]             rd_data
);
	import fcs_pkg::*;
	function automatic int cyc_ceil(input int ns);
		return (ns + `FCS_CLK_NS - 1) / `FCS_CLK_NS;
	endfunction : cyc_ceil
	localparam int SETUP_C = cyc_ceil(`FCS_SETUP_NS);
	localparam int PULSE_C = cyc_ceil(`FCS_PULSE_NS);
	localparam int RECOV_C = cyc_ceil(`FCS_RECOVER_NS);
	typedef enum logic [1:0] {
		FCS_BC_IDLE  = 2'b00,
		FCS_BC_SETUP = 2'b01,
		FCS_BC_PULSE = 2'b11,
		FCS_BC_RECOV = 2'b10
	} fcs_bc_e;
	fcs_bc_e    state_ff;
	logic [3:0] cnt_ff;
	fcs_cyc_s   cyc_ff;
	// A new cycle is taken only when idle
	assign cyc_ready = (state_ff == FCS_BC_IDLE);
	// Cycle sequencing
	always_ff @(posedge ref_clk) begin
		done <= 1'b0;
		if (!rst_n) begin
			state_ff <= FCS_BC_IDLE;
			cnt_ff   <= 4'h0;
			cyc_ff   <= '0;
		end else begin
			case (state_ff)
				FCS_BC_IDLE: if (cyc_valid) begin
					cyc_ff   <= cyc;
					cnt_ff   <= 4'(SETUP_C);
					state_ff <= FCS_BC_SETUP;
				end
				FCS_BC_SETUP: if (cnt_ff <= 4'h1) begin
					cnt_ff   <= 4'(PULSE_C);
					state_ff <= FCS_BC_PULSE;
				end else cnt_ff <= cnt_ff - 4'h1;
				FCS_BC_PULSE: if (cnt_ff <= 4'h1) begin
					cnt_ff   <= 4'(RECOV_C);
					state_ff <= FCS_BC_RECOV;
				end else cnt_ff <= cnt_ff - 4'h1;
				FCS_BC_RECOV: if (cnt_ff <= 4'h1) begin
					state_ff <= FCS_BC_IDLE;
					done     <= 1'b1;
				end else cnt_ff <= cnt_ff - 4'h1;
				default: state_ff <= FCS_BC_IDLE;
			endcase
		end
	end
	// Read data sampled at end of gate pulse
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (state_ff == FCS_BC_PULSE && cnt_ff <= 4'h1
				&& cyc_ff.is_read) begin
			rd_data <= byte_lines_in;
		end
	end
	// Pin drive: strobe falls latching address, rises latching data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pins           <= '{1'b1, 1'b1, 1'b1, 20'h00000};
			byte_lines_out <= 8'h00;
			byte_lines_oe  <= 1'b0;
		end else begin
			pins.addr        <= cyc_ff.addr;
			byte_lines_out   <= cyc_ff.data;
			pins.chip_sel_n  <= (state_ff == FCS_BC_IDLE);
			pins.wr_strobe_n <= !(state_ff == FCS_BC_PULSE
					&& !cyc_ff.is_read);
			pins.out_gate_n  <= !(state_ff == FCS_BC_PULSE
					&& cyc_ff.is_read);
			byte_lines_oe    <= state_ff != FCS_BC_IDLE
					&& !cyc_ff.is_read;
		end
	end
endmodule : fcs_bus_cycle

// File: rtl/fcs_host.sv
`timescale 1ns/1ps
`include "fcs_regs.svh"
// Host side command sequencer for the byte-wide flash
module fcs_host #(
	parameter int POLL_MAX = 100000,
	parameter int GAP_CYC  = `FCS_GAP_US * 1000 / `FCS_CLK_NS
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire fcs_pkg::fcs_req_s req,
	output logic                   rsp_valid,
	output logic [7:0]             rsp_data,
	output logic                   rsp_fail,
	output logic                   busy,
	output fcs_pkg::fcs_pins_s     pins,
	output logic [7:0]             byte_lines_out,
	output logic                   byte_lines_oe,
	input  wire logic [7:0]        byte_lines_in
);
	import fcs_pkg::*;
	// Refuse counts that the poll and window counters cannot hold
	if (POLL_MAX < 1 || GAP_CYC < 2 || GAP_CYC > 65535) begin : g_chk
		$error("fcs_host: bad parameter");
	end
	typedef enum logic [2:0] {
		FCS_H_IDLE  = 3'b000,
		FCS_H_SEND  = 3'b001,
		FCS_H_WAIT  = 3'b011,
		FCS_H_POLL  = 3'b010,
		FCS_H_PWAIT = 3'b110,
		FCS_H_DONE  = 3'b100
	} fcs_h_e;
	fcs_h_e      state_ff;
	fcs_req_s    req_ff;
	logic [2:0]  idx_ff;
	logic [2:0]  len;
	logic [31:0] poll_ff;
	logic [15:0] gap_ff;
	logic        sus_ok_ff;
	logic        erasing_ff;
	logic [7:0]  rsp_data_ff;
	logic        rsp_fail_ff;
	logic        rsp_valid_ff;
	logic        sus_bad;
	logic        res_bad;
	logic        cyc_valid;
	logic        cyc_ready;
	logic        cyc_done;
	logic [7:0]  cyc_rd;
	fcs_cyc_s    cyc;
	// Cycles in a command sequence
	function automatic logic [2:0] seq_len(input fcs_op_e op);
		case (op)
			FCS_OP_RESET3, FCS_OP_AUTOSEL: return 3'd3;
			FCS_OP_PROGRAM:                return 3'd4;
			FCS_OP_CHIP, FCS_OP_SECTOR:    return 3'd6;
			default:                       return 3'd1;
		endcase
	endfunction : seq_len
	// Address and data of cycle i of a sequence
	function automatic fcs_cyc_s seq_cyc(input fcs_req_s r,
			input logic [2:0] i);
		fcs_cyc_s c;
		logic [19:0] u1;
		logic [19:0] u2;
		c  = '{1'b0, r.addr, r.data};
		u1 = {9'h000, `FCS_UNLOCK_ADDR1};
		u2 = {9'h000, `FCS_UNLOCK_ADDR2};
		case (i)
			3'd0: c = '{1'b0, u1, `FCS_UNLOCK_DATA1};
			3'd1: c = '{1'b0, u2, `FCS_UNLOCK_DATA2};
			3'd2: case (r.op)
				FCS_OP_RESET3:  c = '{1'b0, u1, `FCS_CMD_RESET};
				FCS_OP_AUTOSEL: c = '{1'b0, u1, `FCS_CMD_AUTOSEL};
				FCS_OP_PROGRAM: c = '{1'b0, u1, `FCS_CMD_PROGRAM};
				default:        c = '{1'b0, u1, `FCS_CMD_ERASE};
			endcase
			3'd3: if (r.op != FCS_OP_PROGRAM)
				c = '{1'b0, u1, `FCS_UNLOCK_DATA1};
			3'd4: c = '{1'b0, u2, `FCS_UNLOCK_DATA2};
			3'd5: c = (r.op == FCS_OP_CHIP) ?
				'{1'b0, u1, `FCS_CMD_CHIP} :
				'{1'b0, r.addr, `FCS_CMD_SECTOR};
			default: c = '{1'b0, r.addr, r.data};
		endcase
		return c;
	endfunction : seq_cyc
	// Length of the sequence now being sent
	assign len = seq_len(req_ff.op);
	// Single-cycle ops take fixed data, reads take a read cycle
	always_comb begin
		cyc = seq_cyc(req_ff, idx_ff);
		case (req_ff.op)
			FCS_OP_RESET:   cyc = '{1'b0, req_ff.addr, `FCS_CMD_RESET};
			FCS_OP_SUSPEND: cyc = '{1'b0, req_ff.addr, `FCS_CMD_SUSPEND};
			FCS_OP_RESUME:  cyc = '{1'b0, req_ff.addr, `FCS_CMD_RESUME};
			FCS_OP_ADD_SEC: cyc = '{1'b0, req_ff.addr, `FCS_CMD_SECTOR};
			FCS_OP_READ:    cyc = '{1'b1, req_ff.addr, 8'h00};
			default: ;
		endcase
	end
	// Host accepts new work only when idle; no new sequence mid-operation
	assign req_ready = (state_ff == FCS_H_IDLE);
	assign cyc_valid = (state_ff == FCS_H_SEND);
	assign busy      = (state_ff != FCS_H_IDLE);
	assign rsp_valid = rsp_valid_ff;
	assign rsp_data  = rsp_data_ff;
	assign rsp_fail  = rsp_fail_ff;
	// Suspend only means something in a sector erase, resume after suspend
	assign sus_bad = (req_ff.op == FCS_OP_SUSPEND) && !erasing_ff;
	assign res_bad = (req_ff.op == FCS_OP_RESUME) && !sus_ok_ff;
	// Main sequencing
	always_ff @(posedge ref_clk) begin
		rsp_valid_ff <= 1'b0;
		if (!rst_n) begin
			state_ff    <= FCS_H_IDLE;
			req_ff      <= '0;
			idx_ff      <= 3'd0;
			poll_ff     <= 32'h0;
			rsp_data_ff <= 8'h00;
			rsp_fail_ff <= 1'b0;
		end else begin
			case (state_ff)
				FCS_H_IDLE: if (req_valid) begin
					req_ff   <= req;
					idx_ff   <= 3'd0;
					poll_ff  <= 32'h0;
					state_ff <= FCS_H_SEND;
				end
				FCS_H_SEND: if (cyc_ready) state_ff <= FCS_H_WAIT;
				FCS_H_WAIT: if (cyc_done) begin
					rsp_data_ff <= cyc_rd;
					rsp_fail_ff <= sus_bad || res_bad;
					if (req_ff.op == FCS_OP_ADD_SEC && gap_ff == 16'h0) begin
						rsp_fail_ff  <= 1'b1;
						rsp_valid_ff <= 1'b1;
						state_ff     <= FCS_H_IDLE;
					end else if (idx_ff + 3'd1 < len) begin
						idx_ff   <= idx_ff + 3'd1;
						state_ff <= FCS_H_SEND;
					end else if (req_ff.op == FCS_OP_PROGRAM
							|| req_ff.op == FCS_OP_CHIP) begin
						state_ff <= FCS_H_POLL;
					end else begin
						state_ff <= FCS_H_DONE;
					end
				end
				FCS_H_POLL: if (cyc_ready) state_ff <= FCS_H_PWAIT;
				FCS_H_PWAIT: if (cyc_done) begin
					rsp_data_ff <= cyc_rd;                   // Last poll byte
					poll_ff     <= poll_ff + 32'h1;
					// Program done when poll bit matches written bit
					if (cyc_rd[`FCS_POLL_BIT] ==
							((req_ff.op == FCS_OP_CHIP) ? 1'b1 :
							req_ff.data[`FCS_POLL_BIT])) begin
						state_ff <= FCS_H_DONE;
					end else if (cyc_rd[`FCS_TIMEOUT_BIT]
							|| poll_ff >= 32'(POLL_MAX)) begin
						rsp_fail_ff  <= 1'b1;
						rsp_valid_ff <= 1'b1;
						state_ff     <= FCS_H_IDLE;
					end else state_ff <= FCS_H_POLL;
				end
				FCS_H_DONE: begin
					rsp_valid_ff <= 1'b1;
					state_ff     <= FCS_H_IDLE;
				end
				default: state_ff <= FCS_H_IDLE;
			endcase
		end
	end
	// Window for adding sectors after a sector command
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			gap_ff <= 16'h0;
		end else if (cyc_done && state_ff == FCS_H_WAIT
				&& (req_ff.op == FCS_OP_ADD_SEC
				|| (req_ff.op == FCS_OP_SECTOR && idx_ff == 3'd5))) begin
			gap_ff <= 16'(GAP_CYC - 1);
		end else if (gap_ff != 16'h0) begin
			gap_ff <= gap_ff - 16'h1;
		end
	end
	// Tracks sector erase and suspend to judge suspend and resume requests;
	// the end of a sector erase is not seen, so the flag waits for a reset or chip erase command
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			erasing_ff <= 1'b0;
			sus_ok_ff  <= 1'b0;
		end else if (state_ff == FCS_H_DONE) begin
			case (req_ff.op)
				FCS_OP_SECTOR:  erasing_ff <= 1'b1;
				FCS_OP_SUSPEND: sus_ok_ff  <= erasing_ff;
				FCS_OP_RESUME:  sus_ok_ff  <= 1'b0;
				FCS_OP_RESET, FCS_OP_RESET3, FCS_OP_CHIP: begin
					erasing_ff <= 1'b0;
					sus_ok_ff  <= 1'b0;
				end
				default: ;
			endcase
		end
	end
	fcs_bus_cycle u_cycle (
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.cyc_valid      (cyc_valid || state_ff == FCS_H_POLL),
		.cyc_ready      (cyc_ready),
		.cyc            (state_ff == FCS_H_POLL ?
				fcs_cyc_s'{1'b1, req_ff.addr, 8'h00} : cyc),
		.pins           (pins),
		.byte_lines_out (byte_lines_out),
		.byte_lines_oe  (byte_lines_oe),
		.byte_lines_in  (byte_lines_in),
		.done           (cyc_done),
		.rd_data        (cyc_rd)
	);
endmodule : fcs_host

// File: tb/fcs_host_asserts.sv
`timescale 1ns/1ps
// Pin protocol checks on the host sequencer
module fcs_host_asserts (
	input wire logic               ref_clk,
	input wire logic               rst_n,
	input wire logic               req_valid,
	input wire logic               req_ready,
	input wire logic               rsp_valid,
	input wire logic               busy,
	input wire fcs_pkg::fcs_pins_s pins,
	input wire logic [7:0]         byte_lines_out,
	input wire logic               byte_lines_oe
);
	import fcs_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Strobe pulse of three clocks, then high
	sequence s_we_pulse;
		!pins.wr_strobe_n [*3] ##1 pins.wr_strobe_n;
	endsequence
	property p_we_qual;
		!pins.wr_strobe_n |-> !pins.chip_sel_n && pins.out_gate_n;
	endproperty
	a_we_qual: assert property (p_we_qual) else $error("bad write qual");
	property p_rd_qual;
		!pins.out_gate_n |-> pins.wr_strobe_n && !byte_lines_oe;
	endproperty
	a_rd_qual: assert property (p_rd_qual) else $error("bus clash");
	property p_cs_first;
		$fell(pins.wr_strobe_n) |-> $past(pins.chip_sel_n) == 1'b0;
	endproperty
	a_cs_first: assert property (p_cs_first) else $error("cs late");
	property p_we_pulse;
		$fell(pins.wr_strobe_n) |-> s_we_pulse;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("pulse len");
	property p_addr_hold;
		!pins.wr_strobe_n |-> $stable(pins.addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
	property p_data_hold;
		$rose(pins.wr_strobe_n) |-> $past(byte_lines_oe)
			&& $stable(byte_lines_out);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved");
	property p_cs_last;
		$rose(pins.chip_sel_n) |-> pins.wr_strobe_n && pins.out_gate_n;
	endproperty
	a_cs_last: assert property (p_cs_last) else $error("cs early");
	property p_take;
		req_valid && req_ready |=> busy;
	endproperty
	a_take: assert property (p_take) else $error("not busy");
	property p_one_rsp;
		rsp_valid |=> !rsp_valid;
	endproperty
	a_one_rsp: assert property (p_one_rsp) else $error("long rsp");
endmodule : fcs_host_asserts

bind fcs_host fcs_host_asserts u_fcs_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
	.req_ready(req_ready), .rsp_valid(rsp_valid), .busy(busy), .pins(pins),
	.byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe)
);

// File: tb/fcs_flash_model.sv
`timescale 1ns/1ps
// Behavioural byte-wide flash seen from its pins
module fcs_flash_model #(
	parameter logic [7:0] ID0    = 8'h5c, // Arbitrary value
	parameter logic [7:0] ID1    = 8'ha3, // Arbitrary value
	parameter real        GAP_NS = 500.0
) (
	input wire fcs_pkg::fcs_pins_s pins,
	input wire logic [7:0]         dq_in,
	output logic [7:0]             dq_out
);
	import fcs_pkg::*;
	logic [7:0]  mem [0:255];
	logic [7:0]  rd, tgt;
	logic [19:0] lat;
	logic [2:0]  step;
	logic [1:0]  mode; // 0 read, 1 ident, 2 busy, 3 failed
	logic        in_wr, erasing, susp, ok;
	int          cnt, n_sec;
	realtime     t_last;
	// Power up in read mode, array erased
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		{step, mode, in_wr, erasing, susp, rd, tgt} = '0;
		cnt = 0;
		n_sec = 0;
		t_last = 0.0;
	end
	// Decode one command cycle
	task automatic cmd(input logic [19:0] a, input logic [7:0] d);
		if (mode == 2'd2) return;
		if (erasing && d == 8'hb0) susp = 1'b1;
		else if (susp && d == 8'h30) susp = 1'b0;
		else if (erasing && step == 3'd0 && d == 8'h30) begin
			if ($realtime - t_last <= GAP_NS) n_sec++;
		end else begin
			if (!susp) erasing = 1'b0;
			case (step)
			3'd0, 3'd3: ok = a[10:0] == 11'h555 && d == 8'haa;
			3'd1, 3'd4: ok = a[10:0] == 11'h2aa && d == 8'h55;
			3'd2: ok = a[10:0] == 11'h555 && d inside {8'hf0, 8'h90, 8'ha0, 8'h80};
			3'd5: ok = (a[10:0] == 11'h555 && d == 8'h10) || d == 8'h30;
			default: ok = 1'b1;
			endcase
			if (!ok) begin
				step = 3'd0;
				mode = 2'd0;
			end else if (step == 3'd2 && d != 8'h80) begin
				mode = (d == 8'h90) ? 2'd1 : 2'd0;
				step = (d == 8'ha0) ? 3'd6 : 3'd0;
			end else if (step == 3'd5) begin
				step = 3'd0;
				erasing = (d == 8'h30);
				if (d == 8'h10) foreach (mem[i]) mem[i] = 8'hff;
				{tgt, cnt} = {8'hff, 32'sd5};
				if (d == 8'h10) mode = 2'd2;
			end else if (step == 3'd6) begin
				step = 3'd0;
				tgt = d;
				cnt = 3;
				mode = (|(d & ~mem[a[7:0]])) ? 2'd3 : 2'd2;
				if (mode == 2'd2) mem[a[7:0]] = mem[a[7:0]] & d;
			end else step++;
		end
		t_last = $realtime;
	endtask
	// Address on strobe fall, data on rise; either pin may time it
	always @(negedge pins.wr_strobe_n or negedge pins.chip_sel_n) begin
		if (!pins.wr_strobe_n && !pins.chip_sel_n && pins.out_gate_n) begin
			lat = pins.addr;
			in_wr = 1'b1;
		end
	end
	always @(posedge pins.wr_strobe_n or posedge pins.chip_sel_n) begin
		if (in_wr) begin
			in_wr = 1'b0;
			cmd(lat, dq_in);
		end
	end
	// Fetch on gate fall; status while busy
	always @(negedge pins.out_gate_n) begin
		if (mode == 2'd2 && cnt > 0) begin
			cnt--;
			rd = {~tgt[7], 7'h00};
		end else if (mode == 2'd3) rd = {~tgt[7], 2'b01, 5'h00};
		else if (mode == 2'd1) rd = pins.addr[7:0] == 8'h00 ? ID0 :
			(pins.addr[7:0] == 8'h01 ? ID1 : 8'h00);
		else if (erasing && !susp) rd = 8'h00;
		else begin
			mode = 2'd0;
			rd = mem[pins.addr[7:0]];
		end
	end
	// Released lines show the inverse of the last byte
	assign dq_out = (pins.chip_sel_n || pins.out_gate_n) ? ~rd : rd;
endmodule : fcs_flash_model

// File: tb/tb_flash_command_sequencer.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
// Host sequencer against the flash model
module tb_flash_command_sequencer;
	import fcs_pkg::*;
	localparam logic [7:0] ID0 = 8'h5c; // Arbitrary value
	localparam logic [7:0] ID1 = 8'ha3; // Arbitrary value
	logic       ref_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_fail;
	logic       busy, dq_oe;
	logic [7:0] rsp_data, dq_host, dq_dev, dq;
	fcs_req_s   req;
	fcs_pins_s  pins;
	int         fail_count = 0;
	int         tests_run = 0;
	fcs_host #(.POLL_MAX(50), .GAP_CYC(20)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_fail(rsp_fail), .busy(busy), .pins(pins),
		.byte_lines_out(dq_host), .byte_lines_oe(dq_oe), .byte_lines_in(dq)
	);
	fcs_flash_model #(.ID0(ID0), .ID1(ID1), .GAP_NS(500.0)) u_flash (
		.pins(pins), .dq_in(dq), .dq_out(dq_dev)
	);
	// Wire level: host wins while it drives
	assign dq = dq_oe ? dq_host : dq_dev;
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic tick();
		@(posedge ref_clk);
		#2;
	endtask : tick
	// One request, wait for its answer
	task automatic xfer(input fcs_op_e op, input logic [19:0] a,
			input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n++ < 4000) tick();
		req = '{op: op, addr: a, data: d};
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n++ < 4000) tick();
		`CHK(rsp_valid, 1'b1)
	endtask : xfer
	task automatic t_power_up();
		xfer(FCS_OP_READ, 20'h00010, 8'h00);
		`CHK(rsp_data, 8'hff)
	endtask : t_power_up
	task automatic t_ident();
		xfer(FCS_OP_AUTOSEL, 20'h00000, 8'h00);
		xfer(FCS_OP_READ, 20'h12300, 8'h00);
		`CHK(rsp_data, ID0)
		xfer(FCS_OP_READ, 20'h12301, 8'h00);
		`CHK(rsp_data, ID1)
		xfer(FCS_OP_READ, 20'h00000, 8'h00);
		`CHK(rsp_data, ID0)
		xfer(FCS_OP_RESET3, 20'h00000, 8'h00);
		xfer(FCS_OP_READ, 20'h00000, 8'h00);
		`CHK(rsp_data, 8'hff)
	endtask : t_ident
	task automatic t_program();
		xfer(FCS_OP_PROGRAM, 20'h00010, 8'h5a);
		`CHK(rsp_fail, 1'b0)
		`CHK(rsp_data, 8'h5a)
		xfer(FCS_OP_PROGRAM, 20'h00010, 8'ha5);
		`CHK(rsp_fail, 1'b1)
		`CHK(rsp_data[5], 1'b1)
		xfer(FCS_OP_RESET, 20'h00000, 8'h00);
		xfer(FCS_OP_READ, 20'h00010, 8'h00);
		`CHK(rsp_data, 8'h5a)
	endtask : t_program
	task automatic t_chip_erase();
		xfer(FCS_OP_CHIP, 20'h00000, 8'h00);
		`CHK(rsp_fail, 1'b0)
		`CHK(rsp_data[7], 1'b1)
		xfer(FCS_OP_READ, 20'h00010, 8'h00);
		`CHK(rsp_data, 8'hff)
	endtask : t_chip_erase
	task automatic t_sector();
		xfer(FCS_OP_SECTOR, 20'h06000, 8'h00);
		`CHK(rsp_fail, 1'b0)
		xfer(FCS_OP_ADD_SEC, 20'h10000, 8'h00);
		`CHK(rsp_fail, 1'b0)
		xfer(FCS_OP_SUSPEND, 20'h00000, 8'h00);
		`CHK(rsp_fail, 1'b0)
		xfer(FCS_OP_READ, 20'h00010, 8'h00);
		`CHK(rsp_data, 8'hff)
		xfer(FCS_OP_RESUME, 20'h00000, 8'h00);
		`CHK(rsp_fail, 1'b0)
		xfer(FCS_OP_READ, 20'h00010, 8'h00);
		`CHK(rsp_data, 8'h00)
		repeat (60) tick();
		xfer(FCS_OP_ADD_SEC, 20'h20000, 8'h00);
		`CHK(rsp_fail, 1'b1)
		xfer(FCS_OP_RESET, 20'h00000, 8'h00);
		xfer(FCS_OP_READ, 20'h00010, 8'h00);
		`CHK(rsp_data, 8'hff)
		xfer(FCS_OP_RESUME, 20'h00000, 8'h00);
		`CHK(rsp_fail, 1'b1)
		xfer(FCS_OP_SUSPEND, 20'h00000, 8'h00);
		`CHK(rsp_fail, 1'b1)
	endtask : t_sector
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// Cut a hang short
	initial begin
		repeat (40000) @(posedge ref_clk);
		fail_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (20) @(posedge ref_clk);
		#2;
		rst_n = 1'b1;
		tick();
		t_power_up();
		t_ident();
		t_program();
		t_chip_erase();
		t_sector();
		tally_and_finish();
	end
endmodule : tb_flash_command_sequencer
